// >>> common/ssprs_pkg.sv
// Shared constants and types for the serial port restart block
package ssprs_pkg;
	localparam int DATA_W = 8;
	localparam int RELOAD_W = 7;
	localparam int CTRL2_W = 8;
	localparam int BUF_DEPTH = 2;
	// Control-2 field positions, low five bits are the event requests
	localparam int CTRL2_RESTART_POS = 1;
	localparam int CTRL2_EVT_W = 5;
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam logic [7:0] BUF_RESET = 8'h00;
	localparam logic [6:0] RELOAD_RESET = 7'h00;
	localparam logic [6:0] RELOAD_RESTART_MASK = 7'h3F;
	typedef enum logic [2:0] {
		SSPRS_IDLE,
		SSPRS_SCL_LOW,
		SSPRS_SDA_HIGH,
		SSPRS_SCL_RISE,
		SSPRS_BOTH_HIGH,
		SSPRS_SDA_LOW
	} ssprs_state_t;
endpackage : ssprs_pkg

// >>> src/ssprs_buffer.sv
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ssprs_buffer (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [ssprs_pkg::DATA_W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [ssprs_pkg::DATA_W-1:0] out_data_out
);
	logic [ssprs_pkg::DATA_W-1:0] mem_q [ssprs_pkg::BUF_DEPTH];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready_out = (count_q != 2'h2);
	assign out_valid_out = (count_q != 2'h0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_q[0] <= ssprs_pkg::BUF_RESET;
			mem_q[1] <= ssprs_pkg::BUF_RESET;
		end else if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// Head word registered so the data output comes from flip-flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_data_out <= ssprs_pkg::BUF_RESET;
		end else begin
			out_data_out <= mem_q[rd_ptr_q];
		end
	end
endmodule : ssprs_buffer
`default_nettype wire

// >>> src/ssprs_top.sv
// Serial port buffer handshake, pin setup and I2C repeated start sequencer
//
// Functional notes
// - Buffer-full sets when received data lands; a buffer read clears it.
// - Shift register is hidden; software only sees the serial buffer.
// - Enable bit hands pins to the port; reconfigure with enable low.
// - Restart begins only when requested while the logic is idle.
// - Drive SCL low and release SDA together; once low, load low six reload bits.
// - On expiry with SDA high release SCL; once high reload seven bits.
// - After one high period drive SDA low one period with SCL high.
// - Then clear restart request, stop reloading, keep SDA low.
// - Start-detected flag sets as soon as a start is seen on lines.
// - Interrupt flag waits until the final baud period expires.
// - SDA low when SCL rises during restart is a bus collision.
// - SCL low before SDA driven low during restart is a collision.
// - After eight bits and acknowledge, transfer continues with more.
// - Buffer write during restart sets write collision, keeps buffer.
// - Low five control-2 bits ignore writes until restart completes.
// - Port runs as SPI or I2C; I2C has master, slave modes.
`timescale 1ns/1ns
`default_nettype none
module ssprs_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic port_enable_bit_in,
	input wire logic i2c_mode_in,
	input wire logic [ssprs_pkg::RELOAD_W-1:0] baud_reload_value_in,
	input wire logic ctrl2_wr_in,
	input wire logic [ssprs_pkg::CTRL2_W-1:0] ctrl2_wdata_in,
	output logic [ssprs_pkg::CTRL2_W-1:0] port_control_second_out,
	input wire logic buf_wr_in,
	input wire logic [ssprs_pkg::DATA_W-1:0] buf_wdata_in,
	input wire logic buf_rd_in,
	output logic [ssprs_pkg::DATA_W-1:0] serial_buffer_out,
	output logic [ssprs_pkg::DATA_W-1:0] tx_data_out,
	output logic tx_load_out,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	input wire logic [ssprs_pkg::DATA_W-1:0] rx_data_in,
	output logic buffer_full_flag_out,
	output logic write_collision_flag_out,
	input wire logic write_collision_clr_in,
	output logic port_interrupt_flag_out,
	input wire logic port_interrupt_clr_in,
	output logic start_seen_out,
	output logic bus_collision_out,
	input wire logic bus_collision_clr_in,
	output logic pins_assigned_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_s;
	logic sda_s;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_in};
			sda_sync_q <= {sda_sync_q[0], sda_in};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];

	// ----------------------------------------------------------------
	// Sequencer state and baud generator
	// ----------------------------------------------------------------
	ssprs_pkg::ssprs_state_t state_q;
	logic [ssprs_pkg::RELOAD_W-1:0] brg_q;
	logic brg_run_q;
	logic brg_done;
	logic busy;
	logic i2c_on;
	logic collide;
	logic seq_end;

	assign i2c_on = port_enable_bit_in && i2c_mode_in;
	assign busy = (state_q != ssprs_pkg::SSPRS_IDLE);
	assign brg_done = brg_run_q && (brg_q == 7'h00);
	assign seq_end = (state_q == ssprs_pkg::SSPRS_SDA_LOW) && brg_done;

	// Collision checks while the restart runs
	always_comb begin
		collide = 1'b0;
		if ((state_q == ssprs_pkg::SSPRS_SCL_RISE) && scl_s && !scl_prev_q
			&& !sda_s)
			collide = 1'b1;
		if ((state_q == ssprs_pkg::SSPRS_BOTH_HIGH) && !scl_s)
			collide = 1'b1;
	end

	logic restart_req;
	assign restart_req = port_control_second_out[ssprs_pkg::CTRL2_RESTART_POS];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ssprs_pkg::SSPRS_IDLE;
		end else if (!i2c_on || collide) begin
			state_q <= ssprs_pkg::SSPRS_IDLE;
		end else begin
			case (state_q)
				ssprs_pkg::SSPRS_IDLE:
					if (restart_req)
						state_q <= ssprs_pkg::SSPRS_SCL_LOW;
				ssprs_pkg::SSPRS_SCL_LOW:
					if (!scl_s)
						state_q <= ssprs_pkg::SSPRS_SDA_HIGH;
				ssprs_pkg::SSPRS_SDA_HIGH:
					if (brg_done && sda_s)
						state_q <= ssprs_pkg::SSPRS_SCL_RISE;
				ssprs_pkg::SSPRS_SCL_RISE:
					if (scl_s)
						state_q <= ssprs_pkg::SSPRS_BOTH_HIGH;
				ssprs_pkg::SSPRS_BOTH_HIGH:
					if (brg_done && sda_s)
						state_q <= ssprs_pkg::SSPRS_SDA_LOW;
				ssprs_pkg::SSPRS_SDA_LOW:
					if (brg_done)
						state_q <= ssprs_pkg::SSPRS_IDLE;
				default:
					state_q <= ssprs_pkg::SSPRS_IDLE;
			endcase
		end
	end

	// Baud generator: counts down, reloaded at each step
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			brg_q <= ssprs_pkg::RELOAD_RESET;
			brg_run_q <= 1'b0;
		end else if (!i2c_on || collide) begin
			brg_run_q <= 1'b0;
		end else if (state_q == ssprs_pkg::SSPRS_SCL_LOW && !scl_s) begin
			brg_q <= baud_reload_value_in & ssprs_pkg::RELOAD_RESTART_MASK;
			brg_run_q <= 1'b1;
		end else if (state_q == ssprs_pkg::SSPRS_SCL_RISE && scl_s) begin
			brg_q <= baud_reload_value_in;
			brg_run_q <= 1'b1;
		end else if (state_q == ssprs_pkg::SSPRS_BOTH_HIGH && brg_done
			&& sda_s) begin
			brg_q <= baud_reload_value_in;
			brg_run_q <= 1'b1;
		end else if (seq_end) begin
			brg_run_q <= 1'b0;
		end else if (brg_run_q && brg_q != 7'h00) begin
			brg_q <= brg_q - 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Line drive (output enable high pulls the line low)
	// ----------------------------------------------------------------
	logic sda_hold_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sda_hold_q <= 1'b0;
		end else if (!i2c_on || collide || restart_req && !busy) begin
			sda_hold_q <= 1'b0;
		end else if (seq_end) begin
			sda_hold_q <= 1'b1;
		end
	end

	assign pins_assigned_out = port_enable_bit_in;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	always_comb begin
		scl_oe_out = 1'b0;
		sda_oe_out = sda_hold_q;
		case (state_q)
			ssprs_pkg::SSPRS_SCL_LOW,
			ssprs_pkg::SSPRS_SDA_HIGH: begin
				scl_oe_out = 1'b1;
				sda_oe_out = 1'b0;
			end
			ssprs_pkg::SSPRS_SCL_RISE,
			ssprs_pkg::SSPRS_BOTH_HIGH:
				sda_oe_out = 1'b0;
			ssprs_pkg::SSPRS_SDA_LOW:
				sda_oe_out = 1'b1;
			default:
				sda_oe_out = sda_hold_q;
		endcase
	end

	// ----------------------------------------------------------------
	// Control register 2 and status flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_control_second_out <= ssprs_pkg::CTRL2_RESET;
		end else begin
			if (ctrl2_wr_in) begin
				port_control_second_out[7:5] <= ctrl2_wdata_in[7:5];
				if (!busy)
					port_control_second_out[4:0] <= ctrl2_wdata_in[4:0];
			end
			if (seq_end || collide)
				port_control_second_out[ssprs_pkg::CTRL2_RESTART_POS] <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			start_seen_out <= 1'b0;
		end else if (!i2c_on) begin
			start_seen_out <= 1'b0;
		end else if (scl_s && sda_prev_q && !sda_s) begin
			start_seen_out <= 1'b1;
		end else if (scl_s && !sda_prev_q && sda_s) begin
			start_seen_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_interrupt_flag_out <= 1'b0;
			bus_collision_out <= 1'b0;
			write_collision_flag_out <= 1'b0;
		end else begin
			if (seq_end || rx_valid_in && rx_ready_out)
				port_interrupt_flag_out <= 1'b1;
			else if (port_interrupt_clr_in)
				port_interrupt_flag_out <= 1'b0;
			if (collide)
				bus_collision_out <= 1'b1;
			else if (bus_collision_clr_in)
				bus_collision_out <= 1'b0;
			if (buf_wr_in && busy)
				write_collision_flag_out <= 1'b1;
			else if (write_collision_clr_in)
				write_collision_flag_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Serial buffer path
	// ----------------------------------------------------------------
	logic rxb_valid;
	logic [ssprs_pkg::DATA_W-1:0] rxb_data;
	logic take;
	logic take_q;

	// Buffer only takes the next word once software emptied it
	assign take = rxb_valid && !buffer_full_flag_out && !take_q;

	ssprs_buffer u_rx_buf (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(rx_valid_in),
		.in_ready_out(rx_ready_out),
		.in_data_in(rx_data_in),
		.out_valid_out(rxb_valid),
		.out_ready_in(take),
		.out_data_out(rxb_data)
	);

	// Flag and buffer change together, one cycle after the pop
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			take_q <= 1'b0;
		end else begin
			take_q <= take;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			serial_buffer_out <= ssprs_pkg::BUF_RESET;
			buffer_full_flag_out <= 1'b0;
			tx_data_out <= ssprs_pkg::BUF_RESET;
			tx_load_out <= 1'b0;
		end else begin
			tx_load_out <= 1'b0;
			if (take_q) begin
				buffer_full_flag_out <= 1'b1;
			end else if (buf_rd_in) begin
				buffer_full_flag_out <= 1'b0;
			end
			if (take_q)
				serial_buffer_out <= rxb_data;
			if (buf_wr_in && !busy) begin
				serial_buffer_out <= buf_wdata_in;
				tx_data_out <= buf_wdata_in;
				tx_load_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_scl_low_seen;
		state_q == ssprs_pkg::SSPRS_SCL_LOW && !scl_s && i2c_on;
	endsequence

	a_restart_only_idle: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		$rose(busy) |-> $past(restart_req))
		else $error("restart began without request");
	a_scl_drive_low: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		state_q == ssprs_pkg::SSPRS_SCL_LOW |-> scl_oe_out)
		else $error("SCL not driven low");
	a_brg_load_six: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		s_scl_low_seen |=> brg_q == $past(baud_reload_value_in[5:0]))
		else $error("baud load wrong");
	a_sda_low_phase: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		state_q == ssprs_pkg::SSPRS_SDA_LOW |-> sda_oe_out && !scl_oe_out)
		else $error("SDA low phase wrong");
	a_restart_clears: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		seq_end |=> !restart_req && sda_oe_out && !brg_run_q)
		else $error("end of restart wrong");
	a_irq_at_end: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		seq_end |=> port_interrupt_flag_out)
		else $error("interrupt not set");
	a_collision_idle: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		collide |=> bus_collision_out && !busy && !scl_oe_out)
		else $error("collision not handled");
	a_full_on_load: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		take_q |=> buffer_full_flag_out)
		else $error("buffer full not set on load");
	a_wrcoll_keeps_buf: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		buf_wr_in && busy |=> write_collision_flag_out
			&& $stable(tx_data_out))
		else $error("write collision wrong");
	a_ctrl2_locked: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		ctrl2_wr_in && busy && !seq_end && !collide
			|=> $stable(port_control_second_out[4:0]))
		else $error("control 2 written while busy");
endmodule : ssprs_top
`default_nettype wire

// >>> sim/ssprs_bus_peer.sv
// Far side of the I2C bus: pull-ups and a second master
`timescale 1ns/1ns
`default_nettype none
module ssprs_bus_peer (
	input wire logic scl_oe_in,
	input wire logic sda_oe_in,
	input wire logic hold_scl_in,
	input wire logic grab_sda_in,
	output logic scl_out,
	output logic sda_out
);
	logic link_clk = 1'b0;
	logic scl_low_q = 1'b0;
	logic sda_low_q = 1'b0;
	// -----------------------------------------
	// Own timebase of the other master
	// -----------------------------------------
	initial forever begin
		#62 link_clk = 1'b1;
		#63 link_clk = 1'b0;
	end
	always @(posedge link_clk) begin
		scl_low_q <= hold_scl_in;
	end
	// Sends a zero just as the clock is let go
	always @(negedge scl_oe_in or negedge grab_sda_in) begin
		sda_low_q = grab_sda_in;
	end
	// Released lines float to the pull-up level
	assign scl_out = !(scl_oe_in || scl_low_q);
	assign sda_out = !(sda_oe_in || sda_low_q);
endmodule : ssprs_bus_peer
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the serial port restart block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic clk_in = 1'b0, rst_n = 1'b0, en = 1'b0, i2c = 1'b0;
	logic c2_wr = 1'b0, b_wr = 1'b0, b_rd = 1'b0, rx_v = 1'b0;
	logic wc_clr = 1'b0, pi_clr = 1'b0, bc_clr = 1'b0;
	logic hold = 1'b0, grab = 1'b0;
	logic [6:0] reload = 7'h00;
	logic [7:0] c2_wd = 8'h00, b_wd = 8'h00, rx_d = 8'h00, last;
	logic [7:0] c2, sbuf, txd;
	logic txl, rx_rdy, bf, wr_coll, pif, st, bcol, pins;
	logic scl, scl_oe, sda, sda_oe, scl_o, sda_o;
	logic [31:0] lfsr = 32'h18AFDFD1;
	logic [7:0] q[$];
	int err_total = 0, n_compared = 0, i, k, n;
	ssprs_top dut (.clk_in(clk_in), .rst_n_in(rst_n),
		.port_enable_bit_in(en), .i2c_mode_in(i2c),
		.baud_reload_value_in(reload), .ctrl2_wr_in(c2_wr),
		.ctrl2_wdata_in(c2_wd), .port_control_second_out(c2),
		.buf_wr_in(b_wr), .buf_wdata_in(b_wd), .buf_rd_in(b_rd),
		.serial_buffer_out(sbuf), .tx_data_out(txd), .tx_load_out(txl),
		.rx_valid_in(rx_v), .rx_ready_out(rx_rdy), .rx_data_in(rx_d),
		.buffer_full_flag_out(bf), .write_collision_flag_out(wr_coll),
		.write_collision_clr_in(wc_clr), .port_interrupt_flag_out(pif),
		.port_interrupt_clr_in(pi_clr), .start_seen_out(st),
		.bus_collision_out(bcol), .bus_collision_clr_in(bc_clr),
		.pins_assigned_out(pins), .scl_in(scl), .scl_out(scl_o),
		.scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_o),
		.sda_oe_out(sda_oe));
	ssprs_bus_peer peer (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
		.hold_scl_in(hold), .grab_sda_in(grab), .scl_out(scl),
		.sda_out(sda));
	// -----------------------------------------
	// Helpers
	// -----------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic tick(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic strobe(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask : strobe
	task automatic c2w(input logic [7:0] v);
		c2_wd = v;
		strobe(c2_wr);
	endtask : c2w
	task automatic wait_for(ref logic s, input logic v, input int lim);
		k = 0;
		while (s !== v && k < lim) begin
			tick(1);
			k++;
		end
		if (s !== v) begin
			err_total++;
			$display("BAD wait timeout");
			test_done();
		end
	endtask : wait_for
	task automatic do_restart(input logic [6:0] r);
		reload = r;
		c2w(8'h02);
		`CHK("scl drive", 2'b10, {scl_oe, sda_oe})
		n = 0;
		while (scl_oe === 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		`CHK("low span", 1'b1, n >= r[5:0] && n <= r[5:0] + 6)
		wait_for(scl, 1'b1, 5);
		`CHK("sda rel", 1'b0, sda_oe)
		lfsr = nxt(lfsr);
		b_wd = lfsr[7:0];
		strobe(b_wr);
		`CHK("write coll", 1'b1, wr_coll)
		`CHK("buf kept", last, sbuf)
		c2w(8'h1C);
		`CHK("ctrl2 low", 5'h02, c2[4:0])
		wait_for(sda_oe, 1'b1, 300);
		`CHK("scl high", 1'b1, scl)
		tick(4);
		`CHK("start", 2'b10, {st, pif})
		wait_for(pif, 1'b1, 300);
		n = k + 4;
		`CHK("low hold", 1'b1, n >= r + 1 - 3 && n <= r + 4)
		`CHK("done", 3'b010, {c2[1], sda_oe, scl_oe})
		tick(30);
		`CHK("sda held", 1'b1, sda_oe)
		strobe(pi_clr);
		strobe(wc_clr);
		`CHK("write coll clr", 1'b0, wr_coll)
		b_wd = lfsr[15:8];
		b_wr = 1'b1;
		tick(1);
		b_wr = 1'b0;
		wait_for(txl, 1'b1, 5);
		`CHK("tx byte", b_wd, txd)
		tick(1);
		b_wd = lfsr[23:16];
		b_wr = 1'b1;
		tick(1);
		b_wr = 1'b0;
		`CHK("tx next", 2'b11, {txl, txd == b_wd})
		last = b_wd;
	endtask : do_restart
	task automatic test_done;
		$display("checks %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	initial forever #5 clk_in = ~clk_in;
	initial begin
		tick(12);
		rst_n = 1'b1;
		`CHK("reset", 17'h0, {bf, wr_coll, pif, st, bcol, scl_oe, sda_oe, c2, scl_o, sda_o})
		`CHK("buf reset", 8'h00, sbuf)
		en = 1'b1;
		tick(1);
		`CHK("pins on", 1'b1, pins)
		c2w(8'h02);
		tick(20);
		`CHK("spi no rs", 1'b0, scl_oe)
		c2w(8'h00);
		// Fill the receive path while software stalls
		lfsr = nxt(lfsr);
		rx_d = lfsr[7:0];
		rx_v = 1'b1;
		for (i = 0; i < 10; i++) begin
			#2;
			if (rx_rdy === 1'b1) begin
				q.push_back(rx_d);
				lfsr = nxt(lfsr);
				tick(1);
				rx_d = lfsr[7:0];
			end else
				tick(1);
		end
		rx_v = 1'b0;
		`CHK("depth", 3, q.size())
		while (q.size() > 0) begin
			wait_for(bf, 1'b1, 10);
			last = q.pop_front();
			`CHK("rx word", last, sbuf)
			strobe(b_rd);
		end
		tick(3);
		`CHK("bf clr", 1'b0, bf)
		strobe(pi_clr);
		en = 1'b0;
		tick(1);
		`CHK("pins off", 1'b0, pins)
		en = 1'b1;
		i2c = 1'b1;
		for (i = 0; i < 3; i++) begin
			lfsr = nxt(lfsr);
			do_restart(i == 0 ? 7'h45 : i == 1 ? 7'h7F : lfsr[6:0] | 7'h40);
		end
		// Other master pulls SCL low before SDA is driven
		reload = 7'h30;
		c2w(8'h02);
		wait_for(scl_oe, 1'b0, 80);
		tick(6);
		hold = 1'b1;
		wait_for(bcol, 1'b1, 40);
		`CHK("bcol scl", 3'b000, {c2[1], scl_oe, sda_oe})
		hold = 1'b0;
		strobe(bc_clr);
		`CHK("bcol clr", 1'b0, bcol)
		// Other master holds SDA low as SCL rises
		grab = 1'b1;
		c2w(8'h02);
		wait_for(bcol, 1'b1, 120);
		`CHK("bcol sda", 3'b000, {c2[1], scl_oe, sda_oe})
		grab = 1'b0;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
